// [logic/dpbr_pkg.sv]
// Constants, register map and carrier types of the dual-port embedded RAM block.
// Assumes one system clock; port clocks arrive as plain synchronous inputs.
package dpbr_pkg;

  localparam int unsigned NWORD_BITS = 9;
  localparam int unsigned WIDE_BITS  = 18;
  localparam int unsigned ADDR_BITS  = 9;
  localparam int unsigned ROWS       = 256;
  localparam int unsigned ROW_BITS   = 8;
  localparam int unsigned COL_SEL_MAX = 4;
  localparam int unsigned TOTAL_BITS = 4608;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS    = 8'h00;
  localparam logic [7:0] STATUS_OFS  = 8'h04;
  localparam logic [7:0] LD_ADDR_OFS = 8'h08;
  localparam logic [7:0] LD_DATA_OFS = 8'h0c;
  localparam logic [7:0] BLK_ID_OFS  = 8'h10;

  // Control field positions
  localparam int unsigned CTRL_WIDE_POS  = 0;
  localparam int unsigned CTRL_DUAL_POS  = 1;
  localparam int unsigned CTRL_FALL_POS  = 2;
  localparam int unsigned CTRL_ASYNC_POS = 4;
  localparam int unsigned CTRL_ROM_POS   = 6;
  localparam int unsigned CTRL_COL_POS   = 7;
  localparam int unsigned CTRL_BITS      = 9;
  localparam int unsigned STAT_B_POS     = 16;

  localparam logic [8:0] CTRL_RST    = 9'h002;
  localparam logic [3:0] BLK_ID_RST  = 4'h0;
  localparam logic [7:0] LD_ADDR_RST = 8'h00;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic                 clk;
    logic                 ce_n;
    logic                 we;
    logic                 oe;
    logic [ADDR_BITS-1:0] addr;
    logic [WIDE_BITS-1:0] wdata;
  } dpbr_port_s;

  typedef struct packed {
    logic                   clk;
    logic                   ce_n;
    logic                   we;
    logic                   oe;
    logic [COL_SEL_MAX-1:0] sel;
    logic [ADDR_BITS-1:0]   addr;
    logic [WIDE_BITS-1:0]   wdata;
  } dpbr_col_s;

endpackage : dpbr_pkg

// [logic/dpbr_embedded_ram_block.sv]
// Dual-port embedded RAM block with an AXI4-Lite control and preload slave.
// Assumes port and column inputs are synchronous to aclk; port clocks are sampled as levels.
`timescale 1ns/100ps
module dpbr_embedded_ram_block
  import dpbr_pkg::*;
#(
  parameter int unsigned COL_SEL_W = 2
) (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic                 clk_en,
  input  wire dpbr_port_s           port_a,
  input  wire dpbr_port_s           port_b,
  input  wire dpbr_col_s            col_a,
  input  wire dpbr_col_s            col_b,
  output logic [WIDE_BITS-1:0]      dout_a,
  output logic [WIDE_BITS-1:0]      dout_b,
  output logic                      dout_en_a,
  output logic                      dout_en_b,
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic [2:0]           s_axi_awprot,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic [2:0]           s_axi_arprot,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready
);

  if (COL_SEL_W < 1 || COL_SEL_W > COL_SEL_MAX) begin : g_chk
    $error("COL_SEL_W must lie between 1 and 4");
  end
  if (ROWS * WIDE_BITS != TOTAL_BITS) begin : g_chk_size
    $error("Array geometry does not give 4608 bits");
  end

  logic [WIDE_BITS-1:0] mem [ROWS];

  logic [CTRL_BITS-1:0] ctrl_q;
  logic [3:0]           blk_id_q;
  logic [ROW_BITS-1:0]  ld_addr_q;
  logic [15:0]          wcnt_q [2];
  logic [1:0]           pclk_q;
  logic [WIDE_BITS-1:0] rdat_q [2];

  // Row index from a port address in the current organisation
  function automatic logic [ROW_BITS-1:0] row_of(input logic [ADDR_BITS-1:0] a,
                                                 input logic wide);
    row_of = wide ? a[ROW_BITS-1:0] : a[ADDR_BITS-1:1];
  endfunction : row_of

  // Read view of a row: narrow mode returns the addressed half in the low bits
  function automatic logic [WIDE_BITS-1:0] view(input logic [WIDE_BITS-1:0] w,
                                                input logic [ADDR_BITS-1:0] a,
                                                input logic wide);
    if (wide) begin
      view = w;
    end else if (a[0]) begin
      view = {{NWORD_BITS{1'b0}}, w[WIDE_BITS-1:NWORD_BITS]};
    end else begin
      view = {{NWORD_BITS{1'b0}}, w[NWORD_BITS-1:0]};
    end
  endfunction : view

  wire wide = ctrl_q[CTRL_WIDE_POS];
  wire dual = ctrl_q[CTRL_DUAL_POS];
  wire rom  = ctrl_q[CTRL_ROM_POS];

  dpbr_port_s           pin   [2];
  dpbr_col_s            cin   [2];
  logic                 p_clk [2];
  logic                 p_cen [2];
  logic                 p_we  [2];
  logic                 p_oe  [2];
  logic                 p_sel [2];
  logic [ADDR_BITS-1:0] p_adr [2];
  logic [WIDE_BITS-1:0] p_wd  [2];
  logic                 act   [2];
  logic                 wr_hit [2];
  logic                 rd_hit [2];
  logic [ROW_BITS-1:0]  p_row [2];
  logic [WIDE_BITS-1:0] p_mask [2];
  logic [WIDE_BITS-1:0] p_rd  [2];

  assign pin[0] = port_a;
  assign pin[1] = port_b;
  assign cin[0] = col_a;
  assign cin[1] = col_b;

  for (genvar p = 0; p < 2; p++) begin : g_port
    // identical control set per port; column lines or dedicated ones
    wire use_col = ctrl_q[CTRL_COL_POS + p];
    wire col_hit = (cin[p].sel[COL_SEL_W-1:0] == blk_id_q[COL_SEL_W-1:0]);
    // the second port exists only in dual-port organisation
    wire enabled = (p == 0) || dual;
    assign p_clk[p] = use_col ? cin[p].clk   : pin[p].clk;
    assign p_cen[p] = use_col ? cin[p].ce_n  : pin[p].ce_n;
    assign p_we[p]  = use_col ? cin[p].we    : pin[p].we;
    assign p_oe[p]  = use_col ? cin[p].oe    : pin[p].oe;
    assign p_adr[p] = use_col ? cin[p].addr  : pin[p].addr;
    assign p_wd[p]  = use_col ? cin[p].wdata : pin[p].wdata;
    assign p_sel[p] = enabled && (!use_col || col_hit);
    // rising or falling edge chosen per port
    wire rise = p_clk[p] && !pclk_q[p];
    wire fall = !p_clk[p] && pclk_q[p];
    assign act[p] = ctrl_q[CTRL_FALL_POS + p] ? fall : rise;
    // edges count only with the clock enable low
    wire live = act[p] && !p_cen[p] && p_sel[p];
    // write needs write enable and output enable; read-only blocks it
    // a write without output enable is dropped here
    assign wr_hit[p] = live && p_we[p] && p_oe[p] && !rom;
    assign rd_hit[p] = live && !p_we[p];
    assign p_row[p]  = row_of(p_adr[p], wide);
    // parity bits travel as ordinary data bits
    assign p_mask[p] = wide ? {WIDE_BITS{1'b1}}
                     : (p_adr[p][0] ? {{NWORD_BITS{1'b1}}, {NWORD_BITS{1'b0}}}
                                    : {{NWORD_BITS{1'b0}}, {NWORD_BITS{1'b1}}});
    assign p_rd[p]   = view(mem[p_row[p]], p_adr[p], wide);
  end : g_port

  wire [WIDE_BITS-1:0] wr_pat [2];
  assign wr_pat[0] = wide ? p_wd[0] : {2{p_wd[0][NWORD_BITS-1:0]}};
  assign wr_pat[1] = wide ? p_wd[1] : {2{p_wd[1][NWORD_BITS-1:0]}};

  // Output side: async mode bypasses the read register, which costs a mux on the path
  // asynchronous read straight from the array
  wire [WIDE_BITS-1:0] out_a = ctrl_q[CTRL_ASYNC_POS] ? p_rd[0] : rdat_q[0];
  wire [WIDE_BITS-1:0] out_b = ctrl_q[CTRL_ASYNC_POS + 1] ? p_rd[1] : rdat_q[1];
  // idle level zero when not enabled
  assign dout_en_a = p_oe[0] && p_sel[0] && !p_we[0];
  assign dout_en_b = p_oe[1] && p_sel[1] && !p_we[1];
  assign dout_a    = dout_en_a ? out_a : '0;
  assign dout_b    = dout_en_b ? out_b : '0;

  // AXI4-Lite slave
  logic        aw_q;
  logic        w_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction : merge

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == CTRL_OFS) || (a == STATUS_OFS) || (a == LD_ADDR_OFS) ||
             (a == LD_DATA_OFS) || (a == BLK_ID_OFS);
  endfunction : mapped

  assign s_axi_awready = clk_en && !aw_q && !bvalid_q;
  assign s_axi_wready  = clk_en && !w_q && !bvalid_q;
  assign s_axi_arready = clk_en && !rvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  wire        do_wr  = aw_q && w_q;
  wire [31:0] w_ctrl = merge({{(32-CTRL_BITS){1'b0}}, ctrl_q}, wdata_q, wstrb_q);
  wire [31:0] w_blk  = merge({28'h0000000, blk_id_q}, wdata_q, wstrb_q);
  wire [31:0] w_lda  = merge({24'h000000, ld_addr_q}, wdata_q, wstrb_q);
  wire [31:0] w_ldd  = merge({14'h0000, mem[ld_addr_q]}, wdata_q, wstrb_q);
  wire        ld_wr  = do_wr && (awaddr_q == LD_DATA_OFS);

  wire [31:0] rd_mux =
    (s_axi_araddr == CTRL_OFS)    ? {{(32-CTRL_BITS){1'b0}}, ctrl_q} :
    (s_axi_araddr == STATUS_OFS)  ? {wcnt_q[1], wcnt_q[0]} :
    (s_axi_araddr == LD_ADDR_OFS) ? {24'h000000, ld_addr_q} :
    (s_axi_araddr == LD_DATA_OFS) ? {14'h0000, mem[ld_addr_q]} :
    (s_axi_araddr == BLK_ID_OFS)  ? {28'h0000000, blk_id_q} : 32'h00000000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= RESP_OKAY;
      ctrl_q <= CTRL_RST;
      blk_id_q <= BLK_ID_RST;
      ld_addr_q <= LD_ADDR_RST;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
        if (awaddr_q == CTRL_OFS) begin
          ctrl_q <= w_ctrl[CTRL_BITS-1:0];
        end
        if (awaddr_q == BLK_ID_OFS) begin
          blk_id_q <= w_blk[3:0];
        end
        if (awaddr_q == LD_ADDR_OFS) begin
          ld_addr_q <= w_lda[ROW_BITS-1:0];
        end
        if (ld_wr) begin
          ld_addr_q <= ld_addr_q + 8'h01;
        end
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        rvalid_q <= 1'b1;
        rdata_q <= rd_mux;
        rresp_q <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_q && s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // Port edge detect, read registers and write counters
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pclk_q <= 2'b00;
      rdat_q[0] <= '0;
      rdat_q[1] <= '0;
      wcnt_q[0] <= 16'h0000;
      wcnt_q[1] <= 16'h0000;
    end else if (clk_en) begin
      pclk_q <= {p_clk[1], p_clk[0]};
      for (int p = 0; p < 2; p++) begin
        // read register loads on the active edge
        if (rd_hit[p]) begin
          rdat_q[p] <= p_rd[p];
        end
        if (wr_hit[p]) begin
          wcnt_q[p] <= wcnt_q[p] + 16'h0001;
        end
      end
    end
  end

  // Array writes; bus preload first so a port write to the same row wins
  always_ff @(posedge aclk) begin
    if (clk_en) begin
      if (ld_wr) begin
        mem[ld_addr_q] <= w_ldd[WIDE_BITS-1:0];
      end
      for (int p = 0; p < 2; p++) begin
        if (wr_hit[p]) begin
          mem[p_row[p]] <= (mem[p_row[p]] & ~p_mask[p]) | (wr_pat[p] & p_mask[p]);
        end
      end
    end
  end

endmodule : dpbr_embedded_ram_block

// [test/dpbr_checker.sv]
// Port and bus timing checks for the dual-port embedded RAM block.
// Assumes binding to the block's top, one clock domain, reset synchronous active low.
`timescale 1ns/100ps
module dpbr_checker
  import dpbr_pkg::*;
#(
  parameter int unsigned COL_SEL_W = 2
) (
  input wire logic                 aclk,
  input wire logic                 aresetn,
  input wire logic                 clk_en,
  input wire dpbr_port_s           port_a,
  input wire logic [WIDE_BITS-1:0] dout_a,
  input wire logic [WIDE_BITS-1:0] dout_b,
  input wire logic                 dout_en_a,
  input wire logic                 dout_en_b,
  input wire logic                 s_axi_awvalid,
  input wire logic                 s_axi_awready,
  input wire logic                 s_axi_wvalid,
  input wire logic                 s_axi_wready,
  input wire logic [1:0]           s_axi_bresp,
  input wire logic                 s_axi_bvalid,
  input wire logic                 s_axi_bready,
  input wire logic                 s_axi_arvalid,
  input wire logic                 s_axi_arready,
  input wire logic [31:0]          s_axi_rdata,
  input wire logic                 s_axi_rvalid,
  input wire logic                 s_axi_rready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  idle_a_a: assert property (!dout_en_a |-> dout_a == '0)
    else $error("port A output not idle");
  idle_b_a: assert property (!dout_en_b |-> dout_b == '0)
    else $error("port B output not idle");
  read_gate_a: assert property (dout_en_a |-> port_a.oe && !port_a.we)
    else $error("port A drives data outside a read");
  // Clock edges with the enable high must leave the read word alone
  ce_hold_a: assert property (port_a.ce_n && $past(port_a.ce_n) && $stable(port_a.addr)
    && dout_en_a && $past(dout_en_a) |-> $stable(dout_a))
    else $error("port A output moved with clock disabled");
  bhold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  rhold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  ar_busy_a: assert property (s_axi_rvalid || !clk_en |-> !s_axi_arready)
    else $error("read address taken while busy");
  w_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  r_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  b_lat_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");

  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && !s_axi_rready);
  cover property (dout_en_b);
endmodule : dpbr_checker

bind dpbr_embedded_ram_block dpbr_checker #(.COL_SEL_W(COL_SEL_W)) dpbr_checker_i (
  .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en), .port_a(port_a),
  .dout_a(dout_a), .dout_b(dout_b), .dout_en_a(dout_en_a), .dout_en_b(dout_en_b),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// [test/dpbr_fabric_model.sv]
// Fabric user logic driving one RAM port.
// Assumes aclk from the bench; port clock is a slow level toggled on aclk.
`timescale 1ns/100ps
module dpbr_fabric_model
  import dpbr_pkg::*;
(
  input wire logic aclk,
  output dpbr_port_s p
);
  initial begin
    p = '0;
    p.ce_n = 1'b1;
  end

  function automatic logic [8:0] par9(input logic [7:0] b);
    return {^b, b};
  endfunction : par9

  // One full port clock pulse; each level lasts two aclk cycles
  task automatic put(input logic [8:0] a, input logic [17:0] d, input logic w, o, cen);
    @(posedge aclk);
    p.addr <= a;
    p.wdata <= d;
    p.we <= w;
    p.oe <= o;
    p.ce_n <= cen;
    repeat (2) @(posedge aclk);
    p.clk <= 1'b1;
    repeat (2) @(posedge aclk);
    p.clk <= 1'b0;
    repeat (2) @(posedge aclk);
    // Released data lines do not keep the old value
    p.wdata <= ~d;
    @(negedge aclk);
  endtask : put

  task automatic look(input logic [8:0] a);
    @(posedge aclk);
    p.addr <= a;
    p.we <= 1'b0;
    p.oe <= 1'b1;
    p.ce_n <= 1'b0;
    @(negedge aclk);
  endtask : look
endmodule : dpbr_fabric_model

// [test/tb.sv]
// Self-checking bench: AXI4-Lite register tasks and fabric port models.
// Assumes a 100 MHz aclk; column lines mirror the port lines plus a select.
`timescale 1ns/100ps
module tb import dpbr_pkg::*; ();
  logic                 aclk, aresetn, clk_en;
  dpbr_port_s           port_a, port_b;
  logic [3:0]           col_sel = 4'h0;
  logic [3:0]           s_axi_wstrb = 4'hf;
  dpbr_col_s            col_a, col_b;
  logic [WIDE_BITS-1:0] dout_a, dout_b;
  logic                 dout_en_a, dout_en_b;
  logic [7:0]           s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0]          s_axi_wdata = 32'h0, s_axi_rdata;
  logic [1:0]           s_axi_bresp, s_axi_rresp;
  logic                 s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic                 s_axi_arvalid = 0, s_axi_rready = 0;
  logic                 s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  int                   miscompares = 0, compares = 0;

  // Column lines mirror the dedicated lines, only the select differs
  assign col_a = {port_a[30:27], col_sel, port_a[26:0]};
  assign col_b = {port_b[30:27], col_sel, port_b[26:0]};

  dpbr_fabric_model pa (.aclk(aclk), .p(port_a));
  dpbr_fabric_model pb (.aclk(aclk), .p(port_b));
  dpbr_embedded_ram_block #(.COL_SEL_W(2)) dpbr_embedded_ram_block_i (
    .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en), .port_a(port_a), .port_b(port_b),
    .col_a(col_a), .col_b(col_b),
    .dout_a(dout_a), .dout_b(dout_b), .dout_en_a(dout_en_a), .dout_en_b(dout_en_b),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic results();
    if (miscompares == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      miscompares++;
    end
  endtask : chk

  task automatic tmo(input int n);
    if (n >= 50) begin
      miscompares++;
      results();
    end
  endtask : tmo

  // Address and data offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'b00);
    int n;
    logic ta, tw, bv;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    ta = 0;
    tw = 0;
    bv = 0;
    for (n = 0; n < 50 && !(ta && tw); n++) begin
      @(negedge aclk);
      ta = ta | s_axi_awready;
      tw = tw | s_axi_wready;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    tmo(n);
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50 && !bv; n++) begin
      @(negedge aclk);
      bv = s_axi_bvalid;
      if (bv) chk(s_axi_bresp, r);
      @(posedge aclk);
    end
    tmo(n);
    s_axi_bready <= 1'b0;
  endtask : wr

  // Ready for data held back a cycle so the slave must hold its answer
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'b00);
    int n;
    logic t;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    t = 0;
    for (n = 0; n < 50 && !t; n++) begin
      @(negedge aclk);
      t = s_axi_arready;
      @(posedge aclk);
    end
    tmo(n);
    s_axi_arvalid <= 1'b0;
    @(posedge aclk) s_axi_rready <= 1'b1;
    t = 0;
    for (n = 0; n < 50 && !t; n++) begin
      @(negedge aclk);
      t = s_axi_rvalid;
      if (t) chk(s_axi_rdata, d);
      if (t) chk(s_axi_rresp, r);
      @(posedge aclk);
    end
    tmo(n);
    s_axi_rready <= 1'b0;
  endtask : rd

  initial begin
    aresetn = 1'b0;
    clk_en = 1'b1;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(CTRL_OFS, 32'h002);
    rd(BLK_ID_OFS, 32'h0);
    rd(STATUS_OFS, 32'h0);
    rd(8'h14, 32'h0, RESP_SLVERR);
    wr(8'h14, 32'h1, RESP_SLVERR);
    pa.put(9'h005, {9'h0, pa.par9(8'ha7)}, 1, 1, 0);
    pb.put(9'h005, 18'h0, 0, 1, 0);
    chk(dout_b, 32'h1a7);
    pa.put(9'h005, 18'h0ff, 1, 1, 1);
    pa.put(9'h005, 18'h0ff, 1, 0, 0);
    pa.put(9'h005, 18'h0, 0, 1, 0);
    chk(dout_a, 32'h1a7);
    pa.put(9'h004, 18'h0, 0, 1, 1);
    chk(dout_a, 32'h1a7);
    pa.put(9'h005, 18'h0, 0, 0, 0);
    chk(dout_a, 32'h0);
    rd(STATUS_OFS, 32'h1);
    wr(CTRL_OFS, 32'h003);
    pa.put(9'h103, 18'h2abcd, 1, 1, 0);
    pb.put(9'h003, 18'h0, 0, 1, 0);
    chk(dout_b, 32'h2abcd);
    wr(CTRL_OFS, 32'h007);
    pa.put(9'h004, 18'h01357, 1, 1, 0);
    pb.put(9'h004, 18'h0, 0, 1, 0);
    chk(dout_b, 32'h1357);
    wr(CTRL_OFS, 32'h023);
    pb.look(9'h004);
    chk(dout_b, 32'h1357);
    pb.look(9'h003);
    chk(dout_b, 32'h2abcd);
    wr(CTRL_OFS, 32'h043);
    wr(LD_ADDR_OFS, 32'h7);
    wr(LD_DATA_OFS, 32'h3c3c3);
    rd(LD_ADDR_OFS, 32'h8);
    pa.put(9'h007, 18'h00001, 1, 1, 0);
    pb.put(9'h007, 18'h0, 0, 1, 0);
    chk(dout_b, 32'h3c3c3);
    wr(LD_ADDR_OFS, 32'h7);
    rd(LD_DATA_OFS, 32'h3c3c3);
    wr(BLK_ID_OFS, 32'h2);
    wr(CTRL_OFS, 32'h183);
    @(posedge aclk) col_sel <= 4'h2;
    pa.put(9'h009, 18'h00155, 1, 1, 0);
    @(posedge aclk) col_sel <= 4'h1;
    pa.put(9'h009, 18'h002aa, 1, 1, 0);
    @(posedge aclk) col_sel <= 4'h2;
    pb.put(9'h009, 18'h0, 0, 1, 0);
    chk(dout_b, 32'h155);
    wr(CTRL_OFS, 32'h001);
    pb.put(9'h009, 18'h0, 1, 1, 0);
    pa.put(9'h009, 18'h0, 0, 1, 0);
    chk(dout_a, 32'h155);
    // Frozen block: a port write must neither land nor count
    @(posedge aclk) clk_en <= 1'b0;
    pa.put(9'h004, 18'h3ffff, 1, 1, 0);
    @(posedge aclk) clk_en <= 1'b1;
    pa.put(9'h004, 18'h0, 0, 1, 0);
    chk(dout_a, 32'h1357);
    chk(dout_en_a, 32'h1);
    rd(CTRL_OFS, 32'h001);
    rd(STATUS_OFS, 32'h4);
    // Mid-run reset: registers return, array keeps its contents
    @(posedge aclk) aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(CTRL_OFS, 32'h002);
    pa.put(9'h012, 18'h0, 0, 1, 0);
    chk(dout_a, 32'h155);
    // Byte strobes: only lane one reaches the control register
    @(posedge aclk) s_axi_wstrb <= 4'h2;
    wr(CTRL_OFS, 32'h1f8);
    @(posedge aclk) s_axi_wstrb <= 4'hf;
    rd(CTRL_OFS, 32'h102);
    results();
  end
endmodule : tb
